// ### pcs_pkg.sv
// Constants and carrier types for the clock synthesizer control block.
// Assumes a classic Wishbone master and clk_i as the system clock.
package pcs_pkg;

    // Register byte offsets
    localparam logic [7:0] SYNTH_CONTROL_REG_OFS = 8'h00;
    localparam logic [7:0] PERIODIC_IRQ_CTL_REG_OFS = 8'h04;

    // Synth control fields
    localparam int SC_SPEED_BIT = 15;
    localparam int SC_HALVE_BIT = 14;
    localparam int SC_MOD_LSB = 8;
    localparam int SC_MOD_W = 6;
    localparam int SC_RATIO_BIT = 7;
    localparam int SC_LOST_BIT = 4;
    localparam int SC_LOCK_BIT = 3;
    localparam int SC_LOSS_RST_BIT = 2;
    localparam int SC_STOP_SRC_BIT = 1;
    localparam int SC_STOP_OUT_BIT = 0;
    localparam logic [15:0] SC_RESET = 16'h3F00;
    localparam logic [15:0] SC_WR_MASK = 16'hFF87;

    // Periodic control fields
    localparam int PI_LEVEL_LSB = 8;
    localparam int PI_LEVEL_W = 3;
    localparam int PI_VEC_LSB = 0;
    localparam int PI_VEC_W = 8;
    localparam logic [15:0] PI_RESET = 16'h000F;
    localparam logic [15:0] PI_WR_MASK = 16'h07FF;

    // Bus clock dividers
    localparam int BUS_DIV_LO = 8;
    localparam int BUS_DIV_HI = 16;

    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int LOCK_TIME_NS = 10000;
    localparam int LOCK_CYCLES = (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PIT_PRESCALE_CYCLES = 2048;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pcs_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pcs_wb_rsp_type;

    typedef struct packed {
        logic [2:0] level;
        logic [7:0] vector;
    } pcs_irq_type;

endpackage

// ### pcs_lock_timer.sv
// Lock acquisition timer for the synthesizer model.
// Assumes restart is a one-cycle pulse in the system clock domain.
`timescale 1ns/1ps
module pcs_lock_timer #(
    parameter int CYCLES = pcs_pkg::LOCK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic restart_i,
    output logic locked_o
);
    localparam int CW = $clog2(CYCLES + 1);

    generate
        if (CYCLES < 1) begin : g_chk
            $error("CYCLES must be at least one");
        end
    endgenerate

    logic [CW-1:0] cnt_r;

    // Any restart drops lock and starts a fresh interval
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            cnt_r <= '0;
        end else if (cnt_r != CW'(CYCLES)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign locked_o = (cnt_r == CW'(CYCLES));
endmodule // pcs_lock_timer

// ### pcs_clk_div.sv
// Even clock divider with a run-time choice of two ratios.
// Assumes ratio changes may shorten one output phase.
`timescale 1ns/1ps
module pcs_clk_div #(
    parameter int DIV_LO = pcs_pkg::BUS_DIV_LO,
    parameter int DIV_HI = pcs_pkg::BUS_DIV_HI
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sel_hi_i,
    output logic clk_o
);
    localparam int CW = $clog2(DIV_HI);

    generate
        if (DIV_LO < 2 || DIV_LO % 2 != 0 || DIV_HI < DIV_LO || DIV_HI % 2 != 0) begin : g_chk
            $error("Dividers must be even and ordered");
        end
    endgenerate

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] half;
    logic clk_r;

    assign half = sel_hi_i ? CW'(DIV_HI / 2 - 1) : CW'(DIV_LO / 2 - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            clk_r <= 1'b0;
        end else if (cnt_r >= half) begin
            cnt_r <= '0;
            clk_r <= ~clk_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign clk_o = clk_r;
endmodule // pcs_clk_div

// ### pcs_clock_ctl.sv
// Clock synthesizer control and periodic tick unit, Wishbone slave.
// Assumes clk_i is the system clock; analogue loop is driven via outputs.
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module pcs_clock_ctl #(
    parameter int LOCK_CYCLES = pcs_pkg::LOCK_CYCLES,
    parameter int PIT_PRESCALE = pcs_pkg::PIT_PRESCALE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pcs_pkg::pcs_wb_req_type wb_req_i,
    output pcs_pkg::pcs_wb_rsp_type wb_rsp_o,
    input wire logic clock_mode_select_pin_i,
    input wire logic reference_lost_i,
    input wire logic low_power_halt_instr_i,
    input wire logic [2:0] ext_irq_level_i,
    input wire logic iack_i,
    input wire logic [2:0] iack_level_i,
    output logic pll_enable_o,
    output logic [11:0] sys_mult_o,
    output logic [12:0] vco_mult_o,
    output logic [2:0] fb_prescale_o,
    output logic [5:0] fb_modulus_o,
    output logic halve_bypass_o,
    output logic vco_enable_o,
    output logic limp_mode_o,
    output logic reset_hold_o,
    output logic loss_reset_req_o,
    output logic core_clk_from_vco_o,
    output logic output_clock_pin_en_o,
    output logic peripheral_bus_clock_o,
    output logic [2:0] irq_level_o,
    output logic periodic_tick_o,
    output logic vector_valid_o,
    output logic [7:0] vector_o
);

    generate
        if (PIT_PRESCALE < 2) begin : g_chk
            $error("PIT_PRESCALE must be at least two");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Reset-time clock mode

    logic pll_mode_r;

    // Pin follows while reset is held; last value kept at release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll_mode_r <= clock_mode_select_pin_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [15:0] synth_control_reg_r;
    logic [15:0] periodic_irq_ctl_reg_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic bus_req;
    logic wr_en;
    logic hit_sc;
    logic hit_pi;
    logic [15:0] bmask;
    logic [15:0] sc_rd;
    logic [15:0] pi_rd;

    assign bus_req = wb_req_i.cyc && wb_req_i.stb && !ack_r;
    assign wr_en = bus_req && wb_req_i.we;
    assign hit_sc = (wb_req_i.adr == pcs_pkg::SYNTH_CONTROL_REG_OFS);
    assign hit_pi = (wb_req_i.adr == pcs_pkg::PERIODIC_IRQ_CTL_REG_OFS);
    assign bmask = {{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

    // No privilege check: every access is served
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            synth_control_reg_r <= pcs_pkg::SC_RESET;
        end else if (wr_en && hit_sc) begin
            synth_control_reg_r <= (synth_control_reg_r & ~(bmask & pcs_pkg::SC_WR_MASK))
                | (wb_req_i.dat[15:0] & bmask & pcs_pkg::SC_WR_MASK);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periodic_irq_ctl_reg_r <= pcs_pkg::PI_RESET;
        end else if (wr_en && hit_pi) begin
            periodic_irq_ctl_reg_r <= (periodic_irq_ctl_reg_r & ~(bmask & pcs_pkg::PI_WR_MASK))
                | (wb_req_i.dat[15:0] & bmask & pcs_pkg::PI_WR_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode

    logic speed_bit;
    logic halve_bit;
    logic [5:0] modulus;
    logic ratio_bit;
    logic loss_reset_sel;
    logic stop_core_src;
    logic stop_out_en;
    logic [2:0] periodic_priority_level;
    logic [7:0] periodic_vector;

    assign speed_bit = synth_control_reg_r[pcs_pkg::SC_SPEED_BIT];
    assign halve_bit = synth_control_reg_r[pcs_pkg::SC_HALVE_BIT];
    assign modulus = synth_control_reg_r[pcs_pkg::SC_MOD_LSB +: pcs_pkg::SC_MOD_W];
    assign ratio_bit = synth_control_reg_r[pcs_pkg::SC_RATIO_BIT];
    assign loss_reset_sel = synth_control_reg_r[pcs_pkg::SC_LOSS_RST_BIT];
    assign stop_core_src = synth_control_reg_r[pcs_pkg::SC_STOP_SRC_BIT];
    assign stop_out_en = synth_control_reg_r[pcs_pkg::SC_STOP_OUT_BIT];
    assign periodic_priority_level = periodic_irq_ctl_reg_r[pcs_pkg::PI_LEVEL_LSB +: pcs_pkg::PI_LEVEL_W];
    assign periodic_vector = periodic_irq_ctl_reg_r[pcs_pkg::PI_VEC_LSB +: pcs_pkg::PI_VEC_W];

    ////////////////////////////////////////////////////////////////////////
    // Effective synthesizer settings

    logic eff_speed;
    logic eff_halve;
    logic [5:0] eff_mod;

    // External mode freezes the loop at reset values
    assign eff_speed = pll_mode_r & speed_bit;
    assign eff_halve = pll_mode_r & halve_bit;
    assign eff_mod = pll_mode_r ? modulus : 6'h3F;

    logic [11:0] sys_mult_nxt;
    logic [12:0] vco_mult_nxt;

    // 4 * (Y+1) * 2^(2W+X), at most 2048
    assign sys_mult_nxt = 12'({6'h00, eff_mod} + 12'h001) << (2 + 2 * eff_speed + eff_halve);
    // Halving stage sits after the VCO, so VCO runs at 2x unless bypassed
    assign vco_mult_nxt = eff_halve ? {1'b0, sys_mult_nxt} : {sys_mult_nxt, 1'b0};

    logic [11:0] sys_mult_r;
    logic [12:0] vco_mult_r;
    logic [2:0] fb_prescale_r;
    logic [5:0] fb_modulus_r;
    logic halve_bypass_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_mult_r <= 12'h100;
            vco_mult_r <= 13'h0200;
            fb_prescale_r <= 3'h1;
            fb_modulus_r <= 6'h3F;
            halve_bypass_r <= 1'b0;
        end else begin
            sys_mult_r <= sys_mult_nxt;
            vco_mult_r <= vco_mult_nxt;
            // Speed bit moves prescaler tap: divide 1 vs 4
            fb_prescale_r <= eff_speed ? 3'h4 : 3'h1;
            fb_modulus_r <= eff_mod;
            halve_bypass_r <= eff_halve;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock tracking

    logic ref_lost_r;
    logic speed_q_r;
    logic [5:0] mod_q_r;
    logic relock;
    logic locked;
    logic sc_written_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_lost_r <= 1'b0;
            speed_q_r <= 1'b0;
            mod_q_r <= 6'h3F;
        end else begin
            ref_lost_r <= reference_lost_i;
            speed_q_r <= eff_speed;
            mod_q_r <= eff_mod;
        end
    end

    // Halving bit is outside the loop and never restarts lock
    assign relock = pll_mode_r && ((speed_q_r != eff_speed) || (mod_q_r != eff_mod)
        || (ref_lost_r != reference_lost_i));

    pcs_lock_timer #(
        .CYCLES(LOCK_CYCLES)
    ) u_lock (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(relock),
        .locked_o(locked)
    );

    // Lock is reported from reset; the write marker is not readable and does not gate lock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sc_written_r <= 1'b0;
        end else if (wr_en && hit_sc) begin
            sc_written_r <= 1'b1;
        end
    end

    logic lock_flag;
    logic lost_flag;

    assign lock_flag = !pll_mode_r || (locked && !ref_lost_r);
    assign lost_flag = pll_mode_r && ref_lost_r;

    ////////////////////////////////////////////////////////////////////////
    // Reset hold and loss handling

    logic hold_r;
    logic loss_rst_r;

    // In synthesizer mode the device stays in reset until first lock after release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_r <= 1'b1;
        end else if (!pll_mode_r || (locked && !sc_written_r) || locked) begin
            hold_r <= 1'b0;
        end
    end

    // Loss with reset selected asserts a level until reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loss_rst_r <= 1'b0;
        end else if (lost_flag && loss_reset_sel) begin
            loss_rst_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Low-power halt clock steering

    logic core_vco_r;
    logic vco_en_r;
    logic out_en_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_vco_r <= 1'b1;
            vco_en_r <= 1'b0;
            out_en_r <= 1'b1;
        end else begin
            core_vco_r <= !low_power_halt_instr_i || stop_core_src;
            vco_en_r <= pll_mode_r && (!low_power_halt_instr_i || stop_core_src);
            out_en_r <= !low_power_halt_instr_i || stop_out_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Peripheral bus clock

    pcs_clk_div #(
        .DIV_LO(pcs_pkg::BUS_DIV_LO),
        .DIV_HI(pcs_pkg::BUS_DIV_HI)
    ) u_bus_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_hi_i(ratio_bit),
        .clk_o(peripheral_bus_clock_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Periodic tick unit

    localparam int PW = $clog2(PIT_PRESCALE);

    logic [PW-1:0] pit_cnt_r;
    logic tick;
    logic pend_r;
    logic pit_claim;
    logic vec_valid_r;
    logic [7:0] vec_r;

    // Prescaler keeps running even with the interrupt disabled
    always_ff @(posedge clk_i) begin
        if (rst_i || tick) begin
            pit_cnt_r <= '0;
        end else begin
            pit_cnt_r <= pit_cnt_r + 1'b1;
        end
    end

    assign tick = (pit_cnt_r == PW'(PIT_PRESCALE - 1));
    assign pit_claim = iack_i && pend_r && (iack_level_i == periodic_priority_level);

    // New tick wins over a same-cycle acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
        end else if (tick && periodic_priority_level != 3'h0) begin
            pend_r <= 1'b1;
        end else if (pit_claim || periodic_priority_level == 3'h0) begin
            pend_r <= 1'b0;
        end
    end

    // Timer claims acknowledge ahead of an equal external level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vec_valid_r <= 1'b0;
            vec_r <= 8'h00;
        end else begin
            vec_valid_r <= pit_claim;
            vec_r <= pit_claim ? periodic_vector : 8'h00;
        end
    end

    logic [2:0] pit_level;

    assign pit_level = pend_r ? periodic_priority_level : 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Read path and acknowledge

    assign sc_rd = {synth_control_reg_r[15:7], 2'b00, lost_flag, lock_flag,
        synth_control_reg_r[2:0]};
    assign pi_rd = periodic_irq_ctl_reg_r & pcs_pkg::PI_WR_MASK;

    // One-cycle ack; unmapped addresses read zero and drop writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req;
            if (bus_req) begin
                rdata_r <= hit_sc ? {16'h0000, sc_rd} : hit_pi ? {16'h0000, pi_rd} : 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign wb_rsp_o.ack = ack_r;
    assign wb_rsp_o.dat = rdata_r;
    assign pll_enable_o = pll_mode_r;
    assign sys_mult_o = sys_mult_r;
    assign vco_mult_o = vco_mult_r;
    assign fb_prescale_o = fb_prescale_r;
    assign fb_modulus_o = fb_modulus_r;
    assign halve_bypass_o = halve_bypass_r;
    assign vco_enable_o = vco_en_r;
    assign limp_mode_o = lost_flag && !loss_reset_sel;
    assign reset_hold_o = hold_r;
    assign loss_reset_req_o = loss_rst_r;
    assign core_clk_from_vco_o = core_vco_r;
    assign output_clock_pin_en_o = out_en_r;
    assign irq_level_o = (pit_level >= ext_irq_level_i) ? pit_level : ext_irq_level_i;
    assign periodic_tick_o = tick;
    assign vector_valid_o = vec_valid_r;
    assign vector_o = vec_r;

endmodule // pcs_clock_ctl

// ### pcs_ref_src.sv
// Reference source model facing the clock synthesizer.
// Assumes run_i comes from the bench; lost_o feeds the loss input.
`timescale 1ns/1ps
module pcs_ref_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic ref_o,
    output logic lost_o
);
    logic [2:0] gap_r;
    ////////////////////////////////////////////////////////////////
    // Oscillator simply stops when removed
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ref_o <= 1'b0;
        else if (run_i)
            ref_o <= ~ref_o;
    end
    // Crude detector: loss after four quiet cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || run_i)
            gap_r <= 3'h0;
        else if (gap_r != 3'h7)
            gap_r <= gap_r + 3'h1;
    end
    assign lost_o = (gap_r >= 3'h4);
endmodule // pcs_ref_src

// ### pcs_clock_ctl_asserts.sv
// Concurrent checks on the clock control block ports.
// Assumes one clock domain and bind onto pcs_clock_ctl.
`timescale 1ns/1ps
module pcs_clock_ctl_asserts #(
    parameter int PIT_PRESCALE = pcs_pkg::PIT_PRESCALE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pcs_pkg::pcs_wb_req_type wb_req_i,
    input wire pcs_pkg::pcs_wb_rsp_type wb_rsp_o,
    input wire logic low_power_halt_instr_i,
    input wire logic [2:0] ext_irq_level_i,
    input wire logic iack_i,
    input wire logic pll_enable_o,
    input wire logic [11:0] sys_mult_o,
    input wire logic [12:0] vco_mult_o,
    input wire logic [2:0] fb_prescale_o,
    input wire logic [5:0] fb_modulus_o,
    input wire logic halve_bypass_o,
    input wire logic vco_enable_o,
    input wire logic limp_mode_o,
    input wire logic core_clk_from_vco_o,
    input wire logic output_clock_pin_en_o,
    input wire logic [2:0] irq_level_o,
    input wire logic periodic_tick_o,
    input wire logic vector_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] tcnt_r;
    logic seen_r;
    ////////////////////////////////////////////////////////////////
    // First tick after reset has no reference point
    always_ff @(posedge clk_i) begin
        if (rst_i)
            tcnt_r <= 16'h0000;
        else if (periodic_tick_o)
            tcnt_r <= 16'h0000;
        else
            tcnt_r <= tcnt_r + 16'h0001;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i)
            seen_r <= 1'b0;
        else if (periodic_tick_o)
            seen_r <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    ack_next_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack longer than one cycle");
    sys_mult_a: assert property ($stable(fb_modulus_o) && $stable(fb_prescale_o) && $stable(halve_bypass_o)
        |-> sys_mult_o == 12'(4 * (fb_modulus_o + 1) * fb_prescale_o * (halve_bypass_o + 1)))
        else $error("system multiplier wrong");
    vco_mult_a: assert property ($stable(sys_mult_o) && $stable(halve_bypass_o)
        |-> vco_mult_o == 13'(sys_mult_o * (2 - halve_bypass_o)))
        else $error("vco multiplier wrong");
    ext_fixed_a: assert property (!pll_enable_o |-> sys_mult_o == 12'h100 && !vco_enable_o && !limp_mode_o)
        else $error("external mode clocks changed");
    limp_pll_a: assert property (limp_mode_o |-> pll_enable_o)
        else $error("limp outside synthesizer mode");
    halt_run_a: assert property (!low_power_halt_instr_i |=> core_clk_from_vco_o && output_clock_pin_en_o)
        else $error("run mode clock routing wrong");
    tick_gap_a: assert property (periodic_tick_o && seen_r |-> tcnt_r == PIT_PRESCALE - 1)
        else $error("tick spacing wrong");
    vec_iack_a: assert property (vector_valid_o |-> $past(iack_i) ##1 !vector_valid_o)
        else $error("vector without acknowledge");
    irq_max_a: assert property (irq_level_o >= ext_irq_level_i)
        else $error("request level below external");
endmodule // pcs_clock_ctl_asserts
bind pcs_clock_ctl pcs_clock_ctl_asserts #(.PIT_PRESCALE(PIT_PRESCALE)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .low_power_halt_instr_i(low_power_halt_instr_i),
    .ext_irq_level_i(ext_irq_level_i), .iack_i(iack_i), .pll_enable_o(pll_enable_o), .sys_mult_o(sys_mult_o),
    .vco_mult_o(vco_mult_o), .fb_prescale_o(fb_prescale_o), .fb_modulus_o(fb_modulus_o),
    .halve_bypass_o(halve_bypass_o), .vco_enable_o(vco_enable_o), .limp_mode_o(limp_mode_o),
    .core_clk_from_vco_o(core_clk_from_vco_o), .output_clock_pin_en_o(output_clock_pin_en_o),
    .irq_level_o(irq_level_o), .periodic_tick_o(periodic_tick_o), .vector_valid_o(vector_valid_o));

// ### test_pcs_clock_ctl.sv
// Self-checking bench for pcs_clock_ctl with a shadow model.
// Assumes short lock and tick counts set by parameters.
`timescale 1ns/1ps
module test_pcs_clock_ctl;
    localparam int LOCK_N = 8;
    localparam int PIT_N = 16;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    pcs_pkg::pcs_wb_req_type req = '0;
    pcs_pkg::pcs_wb_rsp_type rsp;
    logic mode_pin = 1'b1, halt = 1'b0, run = 1'b1, iack = 1'b0;
    logic [2:0] ext_lvl = 3'h0, iack_lvl = 3'h0, pre, irq;
    logic pll_en, halve, vco_en, limp, hold, lrst, core_vco, output_clock_pin_en, bus_clk, tick, vec_v, ref_wave, lost;
    logic [11:0] sys_m;
    logic [12:0] vco_m;
    logic [5:0] modl;
    logic [7:0] vec;
    logic [15:0] rd;
    int error_cnt = 0, checks = 0, seed = 32'h0033, sc, pi, n, w, x, y, v;
    always #2.5 clk_i = ~clk_i;
    pcs_ref_src u_ref (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .ref_o(ref_wave), .lost_o(lost));
    pcs_clock_ctl #(.LOCK_CYCLES(LOCK_N), .PIT_PRESCALE(PIT_N)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(req), .wb_rsp_o(rsp), .clock_mode_select_pin_i(mode_pin), .reference_lost_i(lost),
        .low_power_halt_instr_i(halt), .ext_irq_level_i(ext_lvl), .iack_i(iack), .iack_level_i(iack_lvl),
        .pll_enable_o(pll_en), .sys_mult_o(sys_m), .vco_mult_o(vco_m), .fb_prescale_o(pre),
        .fb_modulus_o(modl), .halve_bypass_o(halve), .vco_enable_o(vco_en), .limp_mode_o(limp),
        .reset_hold_o(hold), .loss_reset_req_o(lrst), .core_clk_from_vco_o(core_vco),
        .output_clock_pin_en_o(output_clock_pin_en), .peripheral_bus_clock_o(bus_clk), .irq_level_o(irq),
        .periodic_tick_o(tick), .vector_valid_o(vec_v), .vector_o(vec));
    ////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d);
        req <= '{1'b1, 1'b1, we, a, 4'h3, {16'h0000, d}};
        // No own limit: only the watchdog may end a stuck wait
        do begin
            @(posedge clk_i);
        end while (rsp.ack !== 1'b1);
        rd = rsp.dat[15:0];
        req <= '0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input int d);
        bus(1'b1, a, 16'(d));
        if (a == 8'h00)
            sc = d & 16'hFFFF;
        if (a == 8'h04)
            pi = d & 16'h07FF;
    endtask
    task automatic rdchk(input logic [7:0] a, input int exp);
        bus(1'b0, a, 16'h0000);
        chk(rd, 16'(exp));
    endtask
    // Shadow read value; bits 6:3 never come from the shadow
    function automatic int esc(input int ls, input int lk);
        return (sc & 16'hFF87) | (ls << 4) | (lk << 3);
    endfunction
    function automatic int fsys(input int r);
        return 4 * (((r >> 8) & 63) + 1) * (1 << (2 * ((r >> 15) & 1) + ((r >> 14) & 1)));
    endfunction
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic do_reset(input logic m);
        rst_i <= 1'b1;
        mode_pin <= m;
        cyc(2);
        rst_i <= 1'b0;
        sc = 16'h3F00;
        pi = 16'h000F;
        cyc(1);
    endtask
    task automatic lvl(input logic b);
        int k;
        k = 0;
        while (bus_clk !== b && k < 40) begin
            @(posedge clk_i);
            k++;
        end
        n += k;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        // Watchdog sized well above the expected run
        #100000;
        error_cnt++;
        results();
    end
    initial begin
        do_reset(1'b1);
        chk(hold, 1'b1);
        chk(sys_m, 256);
        cyc(4);
        chk(hold, 1'b1);
        cyc(LOCK_N + 4);
        chk(hold, 1'b0);
        chk(pll_en, 1'b1);
        rdchk(8'h00, esc(0, 1));
        rdchk(8'h04, 16'h000F);
        wr(8'h04, 16'hFFFF);
        rdchk(8'h04, 16'h07FF);
        rdchk(8'h10, 0);
        for (int i = 0; i < 6; i++) begin
            w = $random(seed) & 1;
            x = $random(seed) & 1;
            y = (i == 0) ? 0 : (i == 1) ? 63 : $random(seed) & 63;
            wr(8'h00, (w << 15) | (x << 14) | (y << 8));
            cyc(2);
            chk(sys_m, 16'(fsys(sc)));
            chk(vco_m, 16'(fsys(sc) * (2 - x)));
            chk(modl, 16'(y));
            chk(pre, w ? 4 : 1);
            chk(halve, 16'(x));
        end
        cyc(LOCK_N + 4);
        wr(8'h00, sc ^ 16'h4000);
        rdchk(8'h00, esc(0, 1));
        wr(8'h00, sc ^ 16'h0100);
        rdchk(8'h00, esc(0, 0));
        cyc(LOCK_N + 4);
        wr(8'h00, sc | 16'h0078);
        rdchk(8'h00, esc(0, 1));
        for (int e = 0; e < 2; e++) begin
            wr(8'h00, (sc & 16'hFF00) | (e << 7));
            lvl(1'b0);
            lvl(1'b1);
            n = 0;
            lvl(1'b0);
            lvl(1'b1);
            chk(16'(n), e ? 16 : 8);
        end
        run <= 1'b0;
        cyc(10);
        chk(limp, 1'b1);
        chk(lrst, 1'b0);
        rdchk(8'h00, esc(1, 0));
        run <= 1'b1;
        cyc(LOCK_N + 4);
        wr(8'h00, sc | 4);
        run <= 1'b0;
        cyc(10);
        chk({lrst, limp}, 16'h0002);
        run <= 1'b1;
        cyc(LOCK_N + 4);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, (sc & 16'hFFFC) | i);
            halt <= 1'b1;
            cyc(3);
            chk({core_vco, output_clock_pin_en, vco_en}, 16'((i >> 1) * 5 + (i & 1) * 2));
            halt <= 1'b0;
            cyc(1);
        end
        for (int l = 0; l < 8; l++) begin
            v = $random(seed) & 255;
            wr(8'h04, (l << 8) | v);
            // Odd levels sit above external, even ones tie with it
            ext_lvl <= 3'(l & 6);
            n = 0;
            while (tick !== 1'b1 && n < 40) begin
                @(posedge clk_i);
                n++;
            end
            chk(tick, 1'b1);
            iack <= 1'b1;
            iack_lvl <= 3'(l);
            cyc(1);
            chk(irq, 16'(l));
            iack <= 1'b0;
            ext_lvl <= 3'h0;
            cyc(1);
            chk({vec_v, vec}, (l != 0) ? (16'h0100 | v) : 0);
            cyc(1);
            chk(irq, 0);
        end
        do_reset(1'b0);
        cyc(3);
        chk({pll_en, hold}, 0);
        rdchk(8'h00, esc(0, 1));
        wr(8'h00, 16'h8500);
        cyc(2);
        chk(sys_m, 256);
        chk(modl, 63);
        run <= 1'b0;
        cyc(10);
        chk(limp, 1'b0);
        rdchk(8'h00, esc(0, 1));
        results();
    end
endmodule // test_pcs_clock_ctl
